// file: mgoc_coord.sv
// module: global operation coordinator of one memory management unit
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RQ1 - chip-selected unit masters, others follow coordination
// RQ2 - lone unit with idle lines works locally
// RQ3 - every writable system register written globally
// RQ4 - copy data byte, mark staging byte loaded
// RQ5 - clearing summary bit clears last-op code
// RQ6 - report finished; master waits for all finished
// RQ7 - refuse load that makes overlapping enabled descriptors
// RQ8 - load ready needs staging 0,1,2,3,6,8
// RQ9 - load read answers 00 pass, ff fail
// RQ10 - disable indexed descriptor at load start
// RQ11 - slave decodes op from selects, strobes, direction
// RQ12 - slave not load ready: load code, hit
// RQ13 - slave collision: hit, result index; else clear
// RQ14 - slave drops hit, finished when coordination released
// RQ15 - master aborts load, answers ff, waits hit clear
// RQ16 - master commits descriptor, answers 00, releases
// RQ17 - processor stages address, space, then reads
// RQ18 - translate ready needs staging 0,1,6
// RQ19 - match: physical address, indexes, translate code
// RQ20 - no match: finished, code cleared
// RQ21 - hit seen: answer 00, wait hit clear
// RQ22 - all finished, no hit: answer ff
// RQ23 - acknowledge until both strobes negate
// RQ24 - load and translate codes distinct, nonzero
module mgoc_coord (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RST_I,
  // processor bus
  input wire logic CS_N_I,
  input wire logic RW_I,
  input wire logic UDS_N_I,
  input wire logic LDS_N_I,
  input wire logic [4:0] REGISTER_SELECT_I,
  input wire logic [15:0] DATA_I,
  output logic [15:0] DATA_O,
  output logic DATA_OE_O,
  output logic DTACK_N_O,
  // peer coordination lines
  output logic OPCOORD_OUT_N_O,
  input wire logic OPCOORD_IN_N_I,
  output logic HIT_REPORT_OUT_N_O,
  input wire logic HIT_REPORT_IN_N_I,
  output logic UNIT_FINISHED_OUT_O,
  input wire logic UNITS_FINISHED_IN_I,
  // status
  output logic [7:0] LOCAL_STATUS_O,
  output logic [7:0] GLOBAL_STATUS_O,
  output logic [7:0] RESULT_INDEX_O,
  output logic [7:0] DESCRIPTOR_INDEX_O,
  output logic [7:0] VECTOR_O
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  mgoc_pkg::mgoc_state_type st_r, st_nxt;
  logic mst_r, mst_nxt, rd_r, rd_nxt, go_n_r, go_n_nxt;
  logic hit_r, hit_nxt, fin_r, fin_nxt, gal_r, gal_nxt;
  logic gat_r, gat_nxt;
  logic [7:0] dout_r, dout_nxt, dp_r, dp_nxt, rdp_r, rdp_nxt;
  logic [7:0] vec_r, vec_nxt, gsr_r, gsr_nxt;
  logic [3:0] code_r, code_nxt;
  logic [1:0] lmisc_r, lmisc_nxt;
  logic [8:0] glb_r, glb_nxt;
  logic [7:0] stg_r [mgoc_pkg::NSTG];
  logic [7:0] stg_nxt [mgoc_pkg::NSTG];
  logic [7:0] ast_r [mgoc_pkg::NAST];
  logic [7:0] ast_nxt [mgoc_pkg::NAST];
  mgoc_pkg::mgoc_desc_type desc_r [mgoc_pkg::NDESC];
  mgoc_pkg::mgoc_desc_type desc_nxt [mgoc_pkg::NDESC];
  logic do_wr, do_clr;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  logic strobe, glob;
  logic [5:0] addr;
  logic [7:0] wbyte;
  logic [15:0] la, lm;
  // rs0 picks the upper byte when both strobes are low
  assign addr = {REGISTER_SELECT_I, UDS_N_I}; // see RQ11
  assign strobe = !UDS_N_I || !LDS_N_I;
  assign wbyte = UDS_N_I ? DATA_I[7:0] : DATA_I[15:8];
  assign glob = !RW_I || addr == mgoc_pkg::A_LOAD ||
                addr == mgoc_pkg::A_XLT;
  assign la = {stg_r[mgoc_pkg::S_LBA_H], stg_r[mgoc_pkg::S_LBA_L]};
  assign lm = {stg_r[mgoc_pkg::S_LAM_H], stg_r[mgoc_pkg::S_LAM_L]};

  // match with full masks, or overlap of two masked ranges
  function automatic logic overlap(mgoc_pkg::mgoc_desc_type d,
                                   logic [15:0] lb, logic [15:0] lk,
                                   logic [7:0] an, logic [7:0] ak);
    overlap = d.en && (((d.logical_base ^ lb) & d.logical_mask & lk) == 16'h0000) &&
              (((d.space_number ^ an) & d.asm_m & ak) == 8'h00);
  endfunction : overlap

  // ------------------------------------------------------------
  // descriptor search, lowest number wins
  // ------------------------------------------------------------
  logic coll, mfound;
  logic [4:0] cidx, midx;
  logic [15:0] phys;
  always_comb begin
    coll = 1'b0;
    mfound = 1'b0;
    cidx = 5'h00;
    midx = 5'h00;
    for (int i = mgoc_pkg::NDESC - 1; i >= 0; i--) begin
      if (overlap(desc_r[i], la, lm, stg_r[mgoc_pkg::S_ASN],
                  stg_r[mgoc_pkg::S_ASM])) begin // see RQ7
        coll = 1'b1;
        cidx = 5'(i);
      end
      if (overlap(desc_r[i], la, 16'hffff, stg_r[mgoc_pkg::S_ASN],
                  8'hff)) begin
        mfound = 1'b1;
        midx = 5'(i);
      end
    end
    phys = (desc_r[midx].pba & desc_r[midx].logical_mask) |
           (la & ~desc_r[midx].logical_mask); // see RQ19
  end

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    mst_nxt = mst_r;
    rd_nxt = rd_r;
    go_n_nxt = go_n_r;
    hit_nxt = hit_r;
    fin_nxt = fin_r;
    dout_nxt = dout_r;
    dp_nxt = dp_r;
    rdp_nxt = rdp_r;
    vec_nxt = vec_r;
    gsr_nxt = gsr_r;
    code_nxt = code_r;
    lmisc_nxt = lmisc_r;
    glb_nxt = glb_r;
    stg_nxt = stg_r;
    ast_nxt = ast_r;
    desc_nxt = desc_r;
    do_wr = 1'b0;
    do_clr = 1'b0;
    case (st_r)
      mgoc_pkg::ST_IDLE: begin
        if (strobe && (!CS_N_I || !OPCOORD_IN_N_I)) begin // see RQ1
          mst_nxt = !CS_N_I;
          rd_nxt = RW_I;
          if (!CS_N_I && !glob) begin
            // local reads live elsewhere; answer as a null read
            dout_nxt = mgoc_pkg::FAIL_BYTE;
            st_nxt = mgoc_pkg::ST_DONE;
          end else begin
            go_n_nxt = CS_N_I; // see RQ1
            if (!RW_I) begin
              do_wr = 1'b1; // see RQ3
              fin_nxt = 1'b1; // see RQ6
              st_nxt = CS_N_I ? mgoc_pkg::ST_SWAIT : mgoc_pkg::ST_WWAIT;
            end else if (addr == mgoc_pkg::A_LOAD) begin
              do_clr = 1'b1; // see RQ10
              st_nxt = mgoc_pkg::ST_LCHK;
            end else if (addr == mgoc_pkg::A_XLT) begin
              st_nxt = mgoc_pkg::ST_XCHK;
            end else begin
              fin_nxt = 1'b1;
              st_nxt = mgoc_pkg::ST_SWAIT;
            end
          end
        end
      end
      mgoc_pkg::ST_WWAIT: begin
        if (UNITS_FINISHED_IN_I) begin // see RQ2 RQ6
          go_n_nxt = 1'b1;
          fin_nxt = 1'b0;
          st_nxt = mgoc_pkg::ST_DONE;
        end
      end
      mgoc_pkg::ST_LCHK: begin
        if (mst_r) begin
          if (coll || !gal_r || !HIT_REPORT_IN_N_I) begin // see RQ15
            code_nxt = (coll || !gal_r) ? mgoc_pkg::LOAD_CODE : 4'h0;
            hit_nxt = coll || !gal_r;
            dout_nxt = mgoc_pkg::FAIL_BYTE; // see RQ9
            go_n_nxt = 1'b1;
            st_nxt = mgoc_pkg::ST_HITW;
          end else begin
            fin_nxt = 1'b1;
            st_nxt = mgoc_pkg::ST_LWAIT;
          end
        end else begin
          fin_nxt = 1'b1;
          st_nxt = mgoc_pkg::ST_SWAIT;
          if (!gal_r) begin
            code_nxt = mgoc_pkg::LOAD_CODE; // see RQ12
            hit_nxt = 1'b1;
          end else if (coll) begin
            hit_nxt = 1'b1; // see RQ13
            rdp_nxt = {3'h0, cidx};
          end else begin
            code_nxt = 4'h0;
          end
        end
      end
      mgoc_pkg::ST_LWAIT: begin
        if (!HIT_REPORT_IN_N_I) begin
          code_nxt = 4'h0; // see RQ15
          dout_nxt = mgoc_pkg::FAIL_BYTE;
          fin_nxt = 1'b0;
          go_n_nxt = 1'b1;
          st_nxt = mgoc_pkg::ST_HITW;
        end else if (UNITS_FINISHED_IN_I) begin // see RQ16
          desc_nxt[dp_r[4:0]] = {1'b1, la, lm,
            stg_r[mgoc_pkg::S_PBA_H], stg_r[mgoc_pkg::S_PBA_L],
            stg_r[mgoc_pkg::S_ASN], stg_r[mgoc_pkg::S_ASM]};
          dout_nxt = mgoc_pkg::PASS_BYTE; // see RQ9
          code_nxt = 4'h0;
          fin_nxt = 1'b0;
          go_n_nxt = 1'b1;
          st_nxt = mgoc_pkg::ST_DONE;
        end
      end
      mgoc_pkg::ST_XCHK: begin
        if (gat_r && mfound) begin // see RQ19
          stg_nxt[mgoc_pkg::S_PBA_H] = phys[15:8];
          stg_nxt[mgoc_pkg::S_PBA_L] = phys[7:0];
          dp_nxt = {3'h0, midx};
          rdp_nxt = {3'h0, midx};
          code_nxt = mgoc_pkg::XLT_CODE; // see RQ24
          if (mst_r) begin
            dout_nxt = mgoc_pkg::PASS_BYTE;
            go_n_nxt = 1'b1;
            st_nxt = mgoc_pkg::ST_DONE;
          end else begin
            hit_nxt = 1'b1;
            fin_nxt = 1'b1;
            st_nxt = mgoc_pkg::ST_SWAIT;
          end
        end else begin
          fin_nxt = 1'b1; // see RQ20
          code_nxt = 4'h0;
          st_nxt = mst_r ? mgoc_pkg::ST_XWAIT : mgoc_pkg::ST_SWAIT;
        end
      end
      mgoc_pkg::ST_XWAIT: begin
        if (!HIT_REPORT_IN_N_I) begin // see RQ21
          dout_nxt = mgoc_pkg::PASS_BYTE;
          fin_nxt = 1'b0;
          go_n_nxt = 1'b1;
          st_nxt = mgoc_pkg::ST_HITW;
        end else if (UNITS_FINISHED_IN_I) begin // see RQ22
          dout_nxt = mgoc_pkg::FAIL_BYTE;
          fin_nxt = 1'b0;
          go_n_nxt = 1'b1;
          st_nxt = mgoc_pkg::ST_DONE;
        end
      end
      mgoc_pkg::ST_HITW: begin
        hit_nxt = 1'b0;
        if (HIT_REPORT_IN_N_I && !hit_r) st_nxt = mgoc_pkg::ST_DONE;
      end
      mgoc_pkg::ST_SWAIT: begin
        if (OPCOORD_IN_N_I) begin // see RQ14
          hit_nxt = 1'b0;
          fin_nxt = 1'b0;
          st_nxt = mgoc_pkg::ST_IDLE;
        end
      end
      mgoc_pkg::ST_DONE: begin
        if (UDS_N_I && LDS_N_I) st_nxt = mgoc_pkg::ST_IDLE; // see RQ23
      end
      default: st_nxt = mgoc_pkg::ST_IDLE;
    endcase
    if (do_clr) desc_nxt[dp_r[4:0]].en = 1'b0;
    if (do_wr) begin // see RQ4
      if (addr < mgoc_pkg::A_AC0) begin
        if (!addr[0]) ast_nxt[addr[4:1]] = wbyte;
      end else if (addr <= mgoc_pkg::A_AC8) begin
        stg_nxt[addr[3:0]] = wbyte;
        glb_nxt[addr[3:0]] = 1'b1;
      end else begin
        case (addr)
          mgoc_pkg::A_DP: dp_nxt = wbyte;
          mgoc_pkg::A_IVR: vec_nxt = wbyte;
          mgoc_pkg::A_GSR: begin
            gsr_nxt = wbyte;
            if (!wbyte[mgoc_pkg::GSR_F_BIT]) code_nxt = 4'h0; // see RQ5
          end
          mgoc_pkg::A_LSR: begin
            code_nxt = wbyte[7:4];
            lmisc_nxt = wbyte[3:2];
          end
          default: ;
        endcase
      end
    end
    // ready bits follow the loaded marks, not the written value
    gal_nxt = (glb_nxt & mgoc_pkg::LOAD_NEED) ==
              mgoc_pkg::LOAD_NEED; // see RQ8
    gat_nxt = (glb_nxt & mgoc_pkg::XLT_NEED) ==
              mgoc_pkg::XLT_NEED; // see RQ18
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      st_r <= mgoc_pkg::ST_IDLE;
      mst_r <= 1'b0;
      rd_r <= 1'b0;
      go_n_r <= 1'b1;
      hit_r <= 1'b0;
      fin_r <= 1'b0;
      gal_r <= 1'b0;
      gat_r <= 1'b0;
      dout_r <= mgoc_pkg::RST_BYTE;
      dp_r <= mgoc_pkg::RST_BYTE;
      rdp_r <= mgoc_pkg::RST_BYTE;
      vec_r <= mgoc_pkg::RST_BYTE;
      gsr_r <= mgoc_pkg::RST_BYTE;
      code_r <= 4'h0;
      lmisc_r <= 2'h0;
      glb_r <= 9'h000;
      stg_r <= '{default: 8'h00};
      ast_r <= '{default: 8'h00};
      desc_r <= '{default: '0};
    end else begin
      st_r <= st_nxt;
      mst_r <= mst_nxt;
      rd_r <= rd_nxt;
      go_n_r <= go_n_nxt;
      hit_r <= hit_nxt;
      fin_r <= fin_nxt;
      gal_r <= gal_nxt;
      gat_r <= gat_nxt;
      dout_r <= dout_nxt;
      dp_r <= dp_nxt;
      rdp_r <= rdp_nxt;
      vec_r <= vec_nxt;
      gsr_r <= gsr_nxt;
      code_r <= code_nxt;
      lmisc_r <= lmisc_nxt;
      glb_r <= glb_nxt;
      stg_r <= stg_nxt;
      ast_r <= ast_nxt;
      desc_r <= desc_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign DATA_O = {dout_r, dout_r};
  assign DATA_OE_O = (st_r == mgoc_pkg::ST_DONE) && rd_r;
  assign DTACK_N_O = st_r != mgoc_pkg::ST_DONE;
  assign OPCOORD_OUT_N_O = go_n_r;
  assign HIT_REPORT_OUT_N_O = !hit_r;
  assign UNIT_FINISHED_OUT_O = fin_r;
  assign LOCAL_STATUS_O = {code_r, lmisc_r, gat_r, gal_r};
  assign GLOBAL_STATUS_O = gsr_r;
  assign RESULT_INDEX_O = rdp_r;
  assign DESCRIPTOR_INDEX_O = dp_r;
  assign VECTOR_O = vec_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);

  AST_MASTER_GO: assert property ( // see RQ1
    st_r == mgoc_pkg::ST_IDLE && strobe && !CS_N_I && glob
    |=> !OPCOORD_OUT_N_O)
    else $error("master did not drive coordination");
  AST_GO_HELD: assert property ( // see RQ6
    st_r == mgoc_pkg::ST_WWAIT && !UNITS_FINISHED_IN_I
    |=> !OPCOORD_OUT_N_O && st_r == mgoc_pkg::ST_WWAIT)
    else $error("coordination released before all finished");
  AST_CODE_CLR: assert property ( // see RQ5
    st_r == mgoc_pkg::ST_IDLE && strobe && !CS_N_I && !RW_I &&
    addr == mgoc_pkg::A_GSR && !wbyte[mgoc_pkg::GSR_F_BIT]
    |=> LOCAL_STATUS_O[7:4] == 4'h0)
    else $error("code field kept after summary clear");
  AST_LOAD_OK: assert property ( // see RQ16
    st_r == mgoc_pkg::ST_LWAIT && HIT_REPORT_IN_N_I &&
    UNITS_FINISHED_IN_I |=> dout_r == mgoc_pkg::PASS_BYTE &&
    desc_r[dp_r[4:0]].en && OPCOORD_OUT_N_O && !DTACK_N_O)
    else $error("load commit wrong");
  AST_LOAD_FAIL: assert property ( // see RQ15
    st_r == mgoc_pkg::ST_LWAIT && !HIT_REPORT_IN_N_I
    |=> dout_r == mgoc_pkg::FAIL_BYTE && OPCOORD_OUT_N_O &&
    !UNIT_FINISHED_OUT_O)
    else $error("load abort wrong");
  AST_XLT_MISS: assert property ( // see RQ22
    st_r == mgoc_pkg::ST_XWAIT && HIT_REPORT_IN_N_I &&
    UNITS_FINISHED_IN_I |=> dout_r == mgoc_pkg::FAIL_BYTE &&
    !DTACK_N_O)
    else $error("translate miss not answered ff");
  AST_SLAVE_END: assert property ( // see RQ14
    st_r == mgoc_pkg::ST_SWAIT && OPCOORD_IN_N_I
    |=> HIT_REPORT_OUT_N_O && !UNIT_FINISHED_OUT_O &&
    st_r == mgoc_pkg::ST_IDLE)
    else $error("slave kept lines after release");
  AST_DTACK_END: assert property ( // see RQ23
    st_r == mgoc_pkg::ST_DONE && UDS_N_I && LDS_N_I
    |=> DTACK_N_O && !DATA_OE_O)
    else $error("acknowledge not withdrawn");
  AST_LOAD_DIS: assert property ( // see RQ10
    st_r == mgoc_pkg::ST_IDLE && strobe && RW_I &&
    addr == mgoc_pkg::A_LOAD && (!CS_N_I || !OPCOORD_IN_N_I)
    |=> !desc_r[dp_r[4:0]].en)
    else $error("indexed descriptor still enabled");
  AST_GAL_SRC: assert property ( // see RQ8
    $rose(LOCAL_STATUS_O[0]) |-> $past(do_wr) &&
    $past(addr) >= mgoc_pkg::A_AC0 && $past(addr) <= mgoc_pkg::A_AC8)
    else $error("load ready set without staging write");
endmodule : mgoc_coord
`default_nettype wire

// file: mgoc_peer.sv
// peer unit model on the shared coordination lines
`timescale 1ns/1ns
`default_nettype none
module mgoc_peer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // scenario controls
  input wire logic [3:0] dly_i,
  input wire logic hit_en_i,
  // shared lines
  input wire logic coord_n_i,
  output logic hit_n_o,
  output logic fin_o
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic hit_n_r;
  logic hit_n_nxt;
  logic fin_r;
  logic fin_nxt;
  // ----------------
  // slave reaction
  // ----------------
  always_comb begin
    cnt_nxt = cnt_r;
    hit_n_nxt = hit_n_r;
    fin_nxt = fin_r;
    if (coord_n_i) begin
      // drop both once coordination is released
      cnt_nxt = 4'h0;
      hit_n_nxt = 1'b1;
      fin_nxt = 1'b0;
    end else if (cnt_r == dly_i) begin
      // slow or prompt finish, hit only when told
      hit_n_nxt = ~hit_en_i;
      fin_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      hit_n_r <= 1'b1;
      fin_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      hit_n_r <= hit_n_nxt;
      fin_r <= fin_nxt;
    end
  end
  assign hit_n_o = hit_n_r;
  assign fin_o = fin_r;
endmodule : mgoc_peer
`default_nettype wire

// file: mgoc_pkg.sv
// package: constants and types of the global operation coordinator
package mgoc_pkg;
  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int NDESC = 32;
  localparam int NSTG = 9;
  localparam int NAST = 16;
  // ------------------------------------------------------------
  // address map: {register_select, rs0}
  // ------------------------------------------------------------
  localparam logic [5:0] A_AC0 = 6'h20;
  localparam logic [5:0] A_AC8 = 6'h28;
  localparam logic [5:0] A_DP = 6'h29;
  localparam logic [5:0] A_IVR = 6'h2b;
  localparam logic [5:0] A_GSR = 6'h2d;
  localparam logic [5:0] A_LSR = 6'h2f;
  localparam logic [5:0] A_XLT = 6'h3d;
  localparam logic [5:0] A_LOAD = 6'h3f;
  // ------------------------------------------------------------
  // staging byte positions
  // ------------------------------------------------------------
  localparam int S_LBA_H = 0;
  localparam int S_LBA_L = 1;
  localparam int S_LAM_H = 2;
  localparam int S_LAM_L = 3;
  localparam int S_PBA_H = 4;
  localparam int S_PBA_L = 5;
  localparam int S_ASN = 6;
  localparam int S_ASM = 8;
  localparam logic [8:0] LOAD_NEED = 9'h14f;
  localparam logic [8:0] XLT_NEED = 9'h043;
  // ------------------------------------------------------------
  // status fields, codes, answers, reset values
  // ------------------------------------------------------------
  localparam int GSR_F_BIT = 7;
  localparam logic [3:0] LOAD_CODE = 4'h1;
  localparam logic [3:0] XLT_CODE = 4'h2;
  localparam logic [7:0] PASS_BYTE = 8'h00;
  localparam logic [7:0] FAIL_BYTE = 8'hff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_WWAIT, ST_LCHK, ST_LWAIT, ST_XCHK,
    ST_XWAIT, ST_HITW, ST_SWAIT, ST_DONE
  } mgoc_state_type;
  typedef struct packed {
    logic en;
    logic [15:0] logical_base;
    logic [15:0] logical_mask;
    logic [15:0] pba;
    logic [7:0] space_number;
    logic [7:0] asm_m;
  } mgoc_desc_type;
endpackage : mgoc_pkg

// file: tb_mgoc_coord.sv
// testbench of the global operation coordinator
`timescale 1ns/1ns
`default_nettype none
module tb_mgoc_coord;
  localparam logic [7:0] LC = {mgoc_pkg::LOAD_CODE, 4'h0};
  localparam logic [7:0] XC = {mgoc_pkg::XLT_CODE, 4'h0};
  typedef struct {
    logic rw;
    logic [5:0] a;
    logic [15:0] d;
    logic [7:0] ed;
    logic [7:0] el;
  } mgoc_row_type;
  mgoc_row_type rows [18] = '{
    '{1'b1, 6'h3f, 16'h0000, 8'hff, LC},
    '{1'b0, 6'h2d, 16'h0080, 8'h00, LC},
    '{1'b0, 6'h2d, 16'h0000, 8'h00, 8'h00},
    '{1'b1, 6'h3d, 16'h0000, 8'hff, 8'h00},
    '{1'b0, 6'h20, 16'h1200, 8'h00, 8'h00},
    '{1'b0, 6'h21, 16'h0034, 8'h00, 8'h00},
    '{1'b0, 6'h26, 16'h0500, 8'h00, 8'h02},
    '{1'b0, 6'h22, 16'hff00, 8'h00, 8'h02},
    '{1'b0, 6'h23, 16'h00ff, 8'h00, 8'h02},
    '{1'b0, 6'h28, 16'hff00, 8'h00, 8'h03},
    '{1'b0, 6'h29, 16'h0003, 8'h00, 8'h03},
    '{1'b1, 6'h3f, 16'h0000, 8'h00, 8'h03},
    '{1'b1, 6'h3d, 16'h0000, 8'h00, XC | 8'h03},
    '{1'b0, 6'h29, 16'h0004, 8'h00, XC | 8'h03},
    '{1'b1, 6'h3f, 16'h0000, 8'hff, LC | 8'h03},
    '{1'b0, 6'h29, 16'h0003, 8'h00, LC | 8'h03},
    '{1'b1, 6'h3f, 16'h0000, 8'h00, 8'h03},
    '{1'b1, 6'h30, 16'h0000, 8'hff, 8'h03}
  };
  logic MCLK_I, RST_I, CS_N_I, RW_I, UDS_N_I, LDS_N_I;
  logic [4:0] REGISTER_SELECT_I;
  logic [15:0] DATA_I, DATA_O;
  logic DATA_OE_O, DTACK_N_O, OPCOORD_OUT_N_O, HIT_REPORT_OUT_N_O;
  logic UNIT_FINISHED_OUT_O;
  logic [7:0] LOCAL_STATUS_O, GLOBAL_STATUS_O, RESULT_INDEX_O;
  logic [7:0] DESCRIPTOR_INDEX_O, VECTOR_O;
  logic go_tb_n, hit_en, peer_hit_n, peer_fin;
  logic [3:0] dly;
  logic [15:0] q;
  int n, n_mismatch, cmp_count;
  // open-drain wiring of the shared lines
  wire coord_w = OPCOORD_OUT_N_O & go_tb_n;
  wire hit_w = HIT_REPORT_OUT_N_O & peer_hit_n;
  wire fin_w = UNIT_FINISHED_OUT_O & peer_fin;
  mgoc_coord i_dut (.MCLK_I(MCLK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
    .RW_I(RW_I), .UDS_N_I(UDS_N_I), .LDS_N_I(LDS_N_I),
    .REGISTER_SELECT_I(REGISTER_SELECT_I), .DATA_I(DATA_I),
    .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .DTACK_N_O(DTACK_N_O),
    .OPCOORD_OUT_N_O(OPCOORD_OUT_N_O), .OPCOORD_IN_N_I(coord_w),
    .HIT_REPORT_OUT_N_O(HIT_REPORT_OUT_N_O), .HIT_REPORT_IN_N_I(hit_w),
    .UNIT_FINISHED_OUT_O(UNIT_FINISHED_OUT_O), .UNITS_FINISHED_IN_I(fin_w),
    .LOCAL_STATUS_O(LOCAL_STATUS_O), .GLOBAL_STATUS_O(GLOBAL_STATUS_O),
    .RESULT_INDEX_O(RESULT_INDEX_O),
    .DESCRIPTOR_INDEX_O(DESCRIPTOR_INDEX_O), .VECTOR_O(VECTOR_O));
  mgoc_peer i_peer (.clk_i(MCLK_I), .rst_i(RST_I), .dly_i(dly),
    .hit_en_i(hit_en), .coord_n_i(coord_w), .hit_n_o(peer_hit_n),
    .fin_o(peer_fin));
  initial begin
    MCLK_I = 1'b0;
    forever #2 MCLK_I = ~MCLK_I;
  end
  // ----------------
  // helpers
  // ----------------
  task automatic chk(input logic [15:0] g, input logic [15:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int c);
    repeat (c) @(posedge MCLK_I);
    #1;
  endtask : tick
  task automatic hang(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s timed out", $time, m);
    end_sim();
  endtask : hang
  // master access: hold everything until acknowledge, then release
  task automatic bus(input logic rw, input logic [5:0] a,
                     input logic [15:0] d);
    int i;
    n = 0;
    CS_N_I = 1'b0;
    RW_I = rw;
    REGISTER_SELECT_I = a[5:1];
    UDS_N_I = a[0];
    LDS_N_I = ~a[0];
    DATA_I = d;
    for (i = 0; i < 60 && DTACK_N_O !== 1'b0; i++) begin
      tick(1);
      n++;
    end
    if (DTACK_N_O !== 1'b0) hang("acknowledge");
    q = DATA_O;
    chk({15'h0, coord_w}, 16'h1, "coord released");
    chk({15'h0, hit_w}, 16'h1, "hit cleared");
    chk({15'h0, UNIT_FINISHED_OUT_O}, 16'h0, "finished");
    chk({15'h0, DATA_OE_O}, {15'h0, rw}, "drive");
    CS_N_I = 1'b1;
    UDS_N_I = 1'b1;
    LDS_N_I = 1'b1;
    for (i = 0; i < 8 && DTACK_N_O !== 1'b1; i++) tick(1);
    chk({DTACK_N_O, DATA_OE_O}, 2'b10, "ack withdrawn");
    tick(1);
  endtask : bus
  task automatic chk_rst();
    chk({DTACK_N_O, DATA_OE_O, OPCOORD_OUT_N_O, HIT_REPORT_OUT_N_O,
         UNIT_FINISHED_OUT_O}, 16'h16, "idle lines");
    chk({LOCAL_STATUS_O, VECTOR_O}, 16'h0, "status");
  endtask : chk_rst
  // ----------------
  // main sequence
  // ----------------
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    RST_I = 1'b1;
    {CS_N_I, RW_I, UDS_N_I, LDS_N_I, go_tb_n} = 5'h1f;
    REGISTER_SELECT_I = 5'h00;
    DATA_I = 16'h0000;
    dly = 4'h0;
    hit_en = 1'b0;
    tick(6);
    RST_I = 1'b0;
    chk_rst();
    $display("test reset done");
    for (int k = 0; k < 18; k++) begin
      bus(rows[k].rw, rows[k].a, rows[k].d);
      if (rows[k].rw) chk(q, {rows[k].ed, rows[k].ed}, "data");
      chk({8'h0, LOCAL_STATUS_O}, {8'h0, rows[k].el}, "lsr");
    end
    chk({8'h0, RESULT_INDEX_O}, 16'h0003, "result index");
    chk({DESCRIPTOR_INDEX_O, GLOBAL_STATUS_O}, 16'h0300, "dp gsr");
    $display("test table done");
    // slow peer: master must wait for every unit
    dly = 4'h6;
    bus(1'b0, 6'h2b, 16'h00a5);
    chk({8'h0, VECTOR_O}, 16'h00a5, "vector");
    chk(16'(n > 6), 16'h1, "waited for peer");
    bus(1'b0, 6'h2d, 16'h0080);
    chk({8'h0, GLOBAL_STATUS_O}, 16'h0080, "gsr");
    $display("test slow peer done");
    // peer reports a hit: remote abort, then peer translation
    dly = 4'h0;
    hit_en = 1'b1;
    bus(1'b1, 6'h3f, 16'h0000);
    chk({q[7:0], LOCAL_STATUS_O}, 16'hff03, "remote abort");
    hit_en = 1'b0;
    bus(1'b1, 6'h3d, 16'h0000);
    chk({q[7:0], LOCAL_STATUS_O}, 16'hff03, "no match");
    hit_en = 1'b1;
    bus(1'b1, 6'h3d, 16'h0000);
    chk({q[7:0], LOCAL_STATUS_O}, 16'h0003, "peer match");
    hit_en = 1'b0;
    $display("test peer hit done");
    // slave write: coordination from outside, own select idle
    go_tb_n = 1'b0;
    RW_I = 1'b0;
    REGISTER_SELECT_I = 5'h15;
    LDS_N_I = 1'b0;
    DATA_I = 16'h003c;
    for (n = 0; n < 20 && UNIT_FINISHED_OUT_O !== 1'b1; n++) begin
      chk({DTACK_N_O, OPCOORD_OUT_N_O}, 16'h3, "slave quiet");
      tick(1);
    end
    if (UNIT_FINISHED_OUT_O !== 1'b1) hang("slave");
    go_tb_n = 1'b1;
    tick(2);
    chk({15'h0, UNIT_FINISHED_OUT_O}, 16'h0, "slave release");
    LDS_N_I = 1'b1;
    tick(2);
    chk({8'h0, VECTOR_O}, 16'h003c, "slave vector");
    $display("test slave done");
    // reset in mid-run
    RST_I = 1'b1;
    tick(6);
    RST_I = 1'b0;
    chk_rst();
    // slave load with nothing staged: load code and hit
    go_tb_n = 1'b0;
    RW_I = 1'b1;
    REGISTER_SELECT_I = 5'h1f;
    LDS_N_I = 1'b0;
    for (n = 0; n < 20 && UNIT_FINISHED_OUT_O !== 1'b1; n++) tick(1);
    if (UNIT_FINISHED_OUT_O !== 1'b1) hang("slave load");
    chk({HIT_REPORT_OUT_N_O, LOCAL_STATUS_O}, {1'b0, LC}, "slv");
    go_tb_n = 1'b1;
    tick(2);
    chk({HIT_REPORT_OUT_N_O, UNIT_FINISHED_OUT_O}, 2'b10, "slv end");
    LDS_N_I = 1'b1;
    tick(1);
    bus(1'b1, 6'h3f, 16'h0000);
    chk({q[7:0], LOCAL_STATUS_O}, {8'hff, LC}, "load after reset");
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_mgoc_coord
`default_nettype wire
